// ==== scu_config_pkg.sv ====
// Shared constants of the system configuration register bank
package scu_config_pkg;

  // Group bases; each group decodes one 256-byte window
  localparam logic [31:0] CHIP_CFG_BASE = 32'h4000_f000;
  localparam logic [31:0] CLK_GEN_BASE  = 32'h4000_1800;
  localparam logic [31:0] LOW_VOLT_BASE = 32'h4000_5100;
  localparam int          GROUP_OFS_BITS = 8;

  // Chip configuration group offsets
  localparam logic [7:0] OFS_MAKER_ID   = 8'h00;
  localparam logic [7:0] OFS_PART_ID    = 8'h04;
  localparam logic [7:0] OFS_REVISION   = 8'h08;
  localparam logic [7:0] OFS_REMAP      = 8'h14;
  localparam logic [7:0] OFS_BOOT_PIN   = 8'h18;
  localparam logic [7:0] OFS_RST_FLAGS  = 8'h1c;
  localparam logic [7:0] OFS_NMI_SEL    = 8'h20;
  localparam logic [7:0] OFS_SW_RESET   = 8'h24;
  localparam logic [7:0] OFS_RST_VALID  = 8'h28;
  localparam logic [7:0] OFS_WUT_CTRL   = 8'h2c;
  localparam logic [7:0] OFS_WUT_RELOAD = 8'h30;

  // Low-voltage group offsets
  localparam logic [7:0] OFS_LVI_CTRL = 8'h00;
  localparam logic [7:0] OFS_LVR_CTRL = 8'h04;
  localparam logic [31:0] LOW_VOLT_RESET = 32'h0000_0000;

  // Clock generation group: offsets and reset values, same order
  localparam int CLK_REG_COUNT = 12;
  localparam logic [7:0] CLK_OFS [CLK_REG_COUNT] = '{
    8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14,
    8'h20, 8'h24, 8'h40, 8'h60, 8'h64, 8'h84};
  localparam logic [31:0] CLK_RST [CLK_REG_COUNT] = '{
    32'h0000_0000, 32'h0000_000c, 32'h0000_0000, 32'h0000_0000,
    32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0002_0000,
    32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0038};

  // Write keys and command codes
  localparam int          KEY_LSB         = 16;
  localparam logic [15:0] REMAP_KEY       = 16'he2f1;
  localparam logic [15:0] SW_RESET_KEY    = 16'h9eb3;
  localparam logic [7:0]  SW_RESET_CODE   = 8'h2d;
  localparam logic [7:0]  REMAP_BOOT_CODE = 8'h69;
  localparam logic [7:0]  REMAP_RESET     = 8'h00;

  // Field layouts and reset values
  localparam int          BOOT_IND_LSB    = 5;
  localparam int          BOOT_PIN_BIT    = 0;
  localparam logic [7:0]  NMI_FIELD_MASK  = 8'hdf;
  localparam logic [7:0]  NMI_RESET       = 8'h00;
  localparam logic [31:0] RESET_VALID_VAL = 32'h0000_0055;
  localparam logic [31:0] WUT_CTRL_MASK   = 32'h0000_0083;
  localparam logic [31:0] WUT_CTRL_RESET  = 32'h0000_0000;
  localparam logic [31:0] WUT_DATA_MASK   = 32'h00ff_ffff;
  localparam logic [31:0] WUT_DATA_RESET  = 32'h0000_1f40;

  // Reset-cause flag positions
  localparam int         FLAG_WIDTH     = 6;
  localparam int         FLAG_MON       = 5;
  localparam int         FLAG_SW        = 4;
  localparam int         FLAG_EXT       = 3;
  localparam int         FLAG_WDT       = 2;
  localparam int         FLAG_LVR       = 1;
  localparam int         FLAG_POR       = 0;
  localparam logic [5:0] FLAGS_AT_POR   = 6'h01;

  // Synchroniser lanes and their idle values
  localparam int         SYNC_WIDTH  = 6;
  localparam int         LANE_EXT    = 0;
  localparam int         LANE_LVR    = 1;
  localparam int         LANE_WDT    = 2;
  localparam int         LANE_MON    = 3;
  localparam int         LANE_DEEP   = 4;
  localparam int         LANE_BOOT   = 5;
  localparam logic [5:0] SYNC_RESET  = 6'h01;

endpackage : scu_config_pkg

// ==== reset_flag_if.sv ====
// Link between the register bank and the reset-cause flag keeper
interface reset_flag_if;
  import scu_config_pkg::*;

  logic [FLAG_WIDTH-1:0] setEvents;
  logic [FLAG_WIDTH-1:0] clearMask;
  logic [FLAG_WIDTH-1:0] flags;

  modport bank (
    output setEvents,
    output clearMask,
    input  flags
  );

  modport keeper (
    input  setEvents,
    input  clearMask,
    output flags
  );

endinterface : reset_flag_if

// ==== reset_cause_keeper.sv ====
// Sticky reset-cause flags with write-one-to-clear
module reset_cause_keeper
  import scu_config_pkg::*;
(
  input wire logic      core_clk,
  input wire logic      resetn,
  reset_flag_if.keeper  flagPort
);

  logic [FLAG_WIDTH-1:0] flags_reg;
  logic [FLAG_WIDTH-1:0] flags_next;

  // Set beats a clear landing in the same cycle
  assign flags_next = (flags_reg & ~flagPort.clearMask) | flagPort.setEvents;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      flags_reg <= FLAGS_AT_POR;
    end else begin
      flags_reg <= flags_next;
    end
  end

  assign flagPort.flags = flags_reg;

endmodule : reset_cause_keeper

// ==== system_config_register_bank.sv ====
// System configuration register bank: identity, remap, boot pin, reset causes, NMI
// Function
// - Decode chip configuration, clock generation and low-voltage groups at fixed bases.
// - Offset zero returns a fixed maker identification word; writes do nothing.
// - Offset four returns the part identification word of the memory variant.
// - Part identification is loaded by hardware from the start-up option read.
// - Revision value sits in bits 7..0; upper bits read zero.
// - Remap writes need the unlock key in bits 31..16, else ignored.
// - Remap writes also need bits 15..8 to invert bits 7..0.
// - Remap code 0x69 puts boot ROM at zero; other values put flash there.
// - Remapped program memory stays reachable at its original address.
// - Power-on clears boot indicator; external pin clears its upper bit only.
// - Boot pin status follows pin level, reads one when not boot function.
// - Every system reset restores boot pin function, pull-up and debounce.
// - Each reset source except deepest wake-up sets its own sticky flag at bits 5..0.
// - A flag clears only when software writes one to it or at power-on.
// - Power-on sets the power-on flag and clears all others.
// - Deepest wake-up may leave the power-on flag clear.
// - Sources active during power-on may also set their flags.
// - Debugger core reset touches only the processor, not these registers.
// - NMI register holds enable, clock-monitor route and source index, reset zero.
// - Reset validation reads 0x55; wake-up timer data resets to 0x1f40.
// - NMI bit 7 enables, bit 6 routes clock monitor, bits 4..0 index.
// - Software system reset only with reset key and command code 0x2d.
module system_config_register_bank
  import scu_config_pkg::*;
#(
  parameter logic [31:0] MAKER_ID = 32'h5a3c_0001, // Arbitrary value
  parameter logic [7:0]  REVISION = 8'h01          // Arbitrary value
) (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic [31:0] busAddr,
  input  wire logic [31:0] busWdata,
  input  wire logic        busWrite,
  input  wire logic        busRead,
  output logic      [31:0] busRdata,
  input  wire logic        extResetPinN,
  input  wire logic        lvrResetReq,
  input  wire logic        wdtResetReq,
  input  wire logic        monResetReq,
  input  wire logic        deepWakeReset,
  input  wire logic        bootPin,
  input  wire logic        bootPinAltSelected,
  input  wire logic        cfgOptionValid,
  input  wire logic [31:0] cfgOptionData,
  output logic             bootRomAtZero,
  output logic      [7:0]  nmiConfig,
  output logic      [1:0]  bootCheckIndicator,
  output logic             systemResetReq,
  output logic             bootPinDefaultLoad
);

  // Group window match on the upper address bits
  function automatic logic in_group(input logic [31:0] addr, input logic [31:0] base);
    in_group = (addr[31:GROUP_OFS_BITS] == base[31:GROUP_OFS_BITS]);
  endfunction : in_group

  // Clock generation lookup: {hit, index}
  function automatic logic [4:0] clk_lookup(input logic [7:0] ofs);
    clk_lookup = 5'h00;
    for (int i = 0; i < CLK_REG_COUNT; i++) begin
      if (CLK_OFS[i] == ofs) begin
        clk_lookup = {1'b1, 4'(i)};
      end
    end
  endfunction : clk_lookup

  // Pin synchronisers and reset-event detection
  logic [SYNC_WIDTH-1:0] rawPins;
  logic [SYNC_WIDTH-1:0] syncStage1_reg;
  logic [SYNC_WIDTH-1:0] syncStage2_reg;
  logic [SYNC_WIDTH-1:0] syncPrev_reg;

  assign rawPins = {bootPin, deepWakeReset, monResetReq,
                    wdtResetReq, lvrResetReq, extResetPinN};

  // Idle value of the external pin is high, so a pin held low at release fires
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      syncStage1_reg <= SYNC_RESET;
    end else begin
      syncStage1_reg <= rawPins;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      syncStage2_reg <= SYNC_RESET;
    end else begin
      syncStage2_reg <= syncStage1_reg;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      syncPrev_reg <= SYNC_RESET;
    end else begin
      syncPrev_reg <= syncStage2_reg;
    end
  end

  wire logic extEvent  = syncPrev_reg[LANE_EXT] & ~syncStage2_reg[LANE_EXT];
  wire logic lvrEvent  = syncStage2_reg[LANE_LVR] & ~syncPrev_reg[LANE_LVR];
  wire logic wdtEvent  = syncStage2_reg[LANE_WDT] & ~syncPrev_reg[LANE_WDT];
  wire logic monEvent  = syncStage2_reg[LANE_MON] & ~syncPrev_reg[LANE_MON];
  wire logic deepEvent = syncStage2_reg[LANE_DEEP] & ~syncPrev_reg[LANE_DEEP];
  wire logic bootLevel = syncStage2_reg[LANE_BOOT];

  // Bus decode
  wire logic [7:0]  ofs       = busAddr[GROUP_OFS_BITS-1:0];
  wire logic        hitChip   = in_group(busAddr, CHIP_CFG_BASE);
  wire logic        hitClk    = in_group(busAddr, CLK_GEN_BASE);
  wire logic        hitLowV   = in_group(busAddr, LOW_VOLT_BASE);
  wire logic [4:0]  clkFind   = clk_lookup(ofs);
  wire logic        clkHit    = hitClk & clkFind[4];
  wire logic [3:0]  clkIdx    = clkFind[3:0];
  wire logic        wrChip    = busWrite & hitChip;
  wire logic [15:0] wrKey     = busWdata[31:KEY_LSB];
  wire logic [7:0]  wrLow     = busWdata[7:0];
  wire logic [7:0]  wrInv     = busWdata[15:8];

  wire logic remapWrite = wrChip & (ofs == OFS_REMAP)
                        & (wrKey == REMAP_KEY)
                        & (wrInv == ~wrLow);
  wire logic swCommand  = wrChip & (ofs == OFS_SW_RESET)
                        & (wrKey == SW_RESET_KEY)
                        & (wrLow == SW_RESET_CODE);
  wire logic bootWrite  = wrChip & (ofs == OFS_BOOT_PIN);
  wire logic flagWrite  = wrChip & (ofs == OFS_RST_FLAGS);
  wire logic nmiWrite   = wrChip & (ofs == OFS_NMI_SEL);
  wire logic wutcWrite  = wrChip & (ofs == OFS_WUT_CTRL);
  wire logic wutdWrite  = wrChip & (ofs == OFS_WUT_RELOAD);
  wire logic lviWrite   = busWrite & hitLowV & (ofs == OFS_LVI_CTRL);
  wire logic lvrWrite   = busWrite & hitLowV & (ofs == OFS_LVR_CTRL);

  // Any warm system reset; a debugger core-only reset never arrives here
  wire logic warmEvent = extEvent | lvrEvent | wdtEvent | monEvent
                       | deepEvent | swCommand;

  // Reset-cause flags
  reset_flag_if flagLink ();

  // Deepest wake-up sets no flag here
  assign flagLink.setEvents = {monEvent, swCommand, extEvent,
                               wdtEvent, lvrEvent, 1'b0};
  assign flagLink.clearMask = flagWrite ? busWdata[FLAG_WIDTH-1:0]
                                        : {FLAG_WIDTH{1'b0}};

  reset_cause_keeper flagKeeper (
    .core_clk (core_clk),
    .resetn   (resetn),
    .flagPort (flagLink.keeper)
  );

  // Chip configuration state
  logic [31:0] partId_reg;
  logic [7:0]  remapSel_reg;
  logic [1:0]  bootInd_reg;
  logic [7:0]  nmi_reg;
  logic [31:0] wutCtrl_reg;
  logic [31:0] wutData_reg;

  // Part code comes from the option read at start-up, not a constant
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      partId_reg <= 32'h0000_0000;
    end else if (cfgOptionValid) begin
      partId_reg <= cfgOptionData;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      remapSel_reg <= REMAP_RESET;
    end else if (warmEvent) begin
      remapSel_reg <= REMAP_RESET;
    end else if (remapWrite) begin
      remapSel_reg <= wrLow;
    end
  end

  // Power-on clears both bits, external pin only the upper one
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      bootInd_reg <= 2'b00;
    end else if (extEvent) begin
      bootInd_reg <= {1'b0, bootInd_reg[0]};
    end else if (bootWrite) begin
      bootInd_reg <= busWdata[BOOT_IND_LSB +: 2];
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      nmi_reg <= NMI_RESET;
    end else if (warmEvent) begin
      nmi_reg <= NMI_RESET;
    end else if (nmiWrite) begin
      nmi_reg <= wrLow & NMI_FIELD_MASK;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wutCtrl_reg <= WUT_CTRL_RESET;
    end else if (warmEvent) begin
      wutCtrl_reg <= WUT_CTRL_RESET;
    end else if (wutcWrite) begin
      wutCtrl_reg <= busWdata & WUT_CTRL_MASK;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wutData_reg <= WUT_DATA_RESET;
    end else if (warmEvent) begin
      wutData_reg <= WUT_DATA_RESET;
    end else if (wutdWrite) begin
      wutData_reg <= busWdata & WUT_DATA_MASK;
    end
  end

  // Clock generation and low-voltage groups (plain storage)
  logic [31:0] clkGen_reg [CLK_REG_COUNT];
  logic [31:0] lviCtrl_reg;
  logic [31:0] lvrCtrl_reg;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < CLK_REG_COUNT; i++) begin
        clkGen_reg[i] <= CLK_RST[i];
      end
    end else begin
      for (int i = 0; i < CLK_REG_COUNT; i++) begin
        if (warmEvent) begin
          clkGen_reg[i] <= CLK_RST[i];
        end else if (busWrite && clkHit && clkIdx == 4'(i)) begin
          clkGen_reg[i] <= busWdata;
        end
      end
    end
  end

  // Only power-on or deepest wake-up clears the low-voltage controls
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      lviCtrl_reg <= LOW_VOLT_RESET;
    end else if (deepEvent) begin
      lviCtrl_reg <= LOW_VOLT_RESET;
    end else if (lviWrite) begin
      lviCtrl_reg <= busWdata;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      lvrCtrl_reg <= LOW_VOLT_RESET;
    end else if (deepEvent) begin
      lvrCtrl_reg <= LOW_VOLT_RESET;
    end else if (lvrWrite) begin
      lvrCtrl_reg <= busWdata;
    end
  end

  // Read data
  wire logic        pinStatus = bootPinAltSelected ? bootLevel : 1'b1;
  wire logic [31:0] bootWord  = {25'h0, bootInd_reg, 4'h0, pinStatus};
  logic      [31:0] chipRead;
  logic      [31:0] lowVRead;
  logic      [31:0] readData;

  // Unused offsets and reserved bits read zero; no error path exists
  always_comb begin
    case (ofs)
      OFS_MAKER_ID:   chipRead = MAKER_ID;
      OFS_PART_ID:    chipRead = partId_reg;
      OFS_REVISION:   chipRead = {24'h0, REVISION};
      OFS_REMAP:      chipRead = {24'h0, remapSel_reg};
      OFS_BOOT_PIN:   chipRead = bootWord;
      OFS_RST_FLAGS:  chipRead = {26'h0, flagLink.flags};
      OFS_NMI_SEL:    chipRead = {24'h0, nmi_reg};
      OFS_RST_VALID:  chipRead = RESET_VALID_VAL;
      OFS_WUT_CTRL:   chipRead = wutCtrl_reg;
      OFS_WUT_RELOAD: chipRead = wutData_reg;
      default:        chipRead = 32'h0000_0000;
    endcase
  end

  always_comb begin
    case (ofs)
      OFS_LVI_CTRL: lowVRead = lviCtrl_reg;
      OFS_LVR_CTRL: lowVRead = lvrCtrl_reg;
      default:      lowVRead = 32'h0000_0000;
    endcase
  end

  assign readData = hitChip ? chipRead
                  : clkHit  ? clkGen_reg[clkIdx]
                  : hitLowV ? lowVRead
                  : 32'h0000_0000;

  // Registered outputs
  logic [31:0] busRdata_reg;
  logic        bootRomAtZero_reg;
  logic        systemResetReq_reg;
  logic        bootPinDefaultLoad_reg;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      busRdata_reg <= 32'h0000_0000;
    end else begin
      busRdata_reg <= busRead ? readData : 32'h0000_0000;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      bootRomAtZero_reg <= 1'b0;
    end else begin
      bootRomAtZero_reg <= (remapSel_reg == REMAP_BOOT_CODE);
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      systemResetReq_reg <= 1'b0;
    end else begin
      systemResetReq_reg <= swCommand;
    end
  end

  // Default pin setup is requested at power-on and at every warm reset
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      bootPinDefaultLoad_reg <= 1'b1;
    end else begin
      bootPinDefaultLoad_reg <= warmEvent;
    end
  end

  // Flash keeps its own address whichever image sits at zero
  assign busRdata           = busRdata_reg;
  assign bootRomAtZero      = bootRomAtZero_reg;
  assign nmiConfig          = nmi_reg;
  assign bootCheckIndicator = bootInd_reg;
  assign systemResetReq     = systemResetReq_reg;
  assign bootPinDefaultLoad = bootPinDefaultLoad_reg;

endmodule : system_config_register_bank

// ==== system_config_register_bank_sva.sv ====
// Port-level checker for the system configuration register bank
module system_config_register_bank_sva
  import scu_config_pkg::*;
#(
  parameter logic [31:0] MAKER_ID = 32'h5a3c_0001, // Arbitrary value
  parameter logic [7:0]  REVISION = 8'h01          // Arbitrary value
) (
  input wire logic        core_clk,
  input wire logic        resetn,
  input wire logic [31:0] busAddr,
  input wire logic [31:0] busWdata,
  input wire logic        busWrite,
  input wire logic        busRead,
  input wire logic [31:0] busRdata,
  input wire logic        bootPinAltSelected,
  input wire logic        bootRomAtZero,
  input wire logic [7:0]  nmiConfig,
  input wire logic        systemResetReq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);

  wire logic       chipHit = busAddr[31:8] == CHIP_CFG_BASE[31:8];
  wire logic       chipRd  = busRead && chipHit;
  wire logic       chipWr  = busWrite && chipHit;
  wire logic [7:0] ofs     = busAddr[7:0];
  wire logic [7:0] wrByte  = busWdata[7:0];
  wire logic       keyOk   = busWdata[31:16] == REMAP_KEY && busWdata[15:8] == ~wrByte;
  wire logic       remapWr = chipWr && ofs == OFS_REMAP;
  wire logic       nmiWr   = chipWr && ofs == OFS_NMI_SEL;
  wire logic       swCmd   = chipWr && ofs == OFS_SW_RESET && busWdata[31:16] == SW_RESET_KEY
                             && wrByte == SW_RESET_CODE;

  idle_read_zero_a: assert property (!busRead |=> busRdata == 32'h0)
    else $error("read data not zero outside a read answer");
  maker_id_read_a: assert property (chipRd && ofs == OFS_MAKER_ID |=> busRdata == MAKER_ID)
    else $error("maker word read wrong");
  revision_read_a: assert property (chipRd && ofs == OFS_REVISION
    |=> busRdata == {24'h0, REVISION})
    else $error("revision read wrong");
  validation_read_a: assert property (chipRd && ofs == OFS_RST_VALID
    |=> busRdata == RESET_VALID_VAL)
    else $error("validation read wrong");
  hole_read_a: assert property (chipRd && (ofs == 8'h0c || ofs == 8'h10)
    |=> busRdata == 32'h0)
    else $error("unused offset read not zero");
  remap_boot_a: assert property (remapWr && keyOk && wrByte == REMAP_BOOT_CODE
    |-> ##2 bootRomAtZero)
    else $error("boot code did not map boot memory");
  remap_flash_a: assert property (remapWr && keyOk && wrByte != REMAP_BOOT_CODE
    |-> ##2 !bootRomAtZero)
    else $error("other code kept boot memory mapped");
  remap_refused_a: assert property (remapWr && !keyOk |=> ##1 $stable(bootRomAtZero))
    else $error("refused remap write changed mapping");
  sw_pulse_a: assert property (swCmd |=> systemResetReq)
    else $error("valid reset command gave no request");
  sw_cause_a: assert property (systemResetReq |-> $past(swCmd))
    else $error("reset request without valid command");
  nmi_write_a: assert property (nmiWr |=> nmiConfig == ($past(wrByte) & NMI_FIELD_MASK))
    else $error("nmi configuration not taken from write");
  boot_pin_idle_a: assert property (chipRd && ofs == OFS_BOOT_PIN && !bootPinAltSelected
    && $past(bootPinAltSelected) == 1'b0 |=> busRdata[BOOT_PIN_BIT])
    else $error("boot status not one without boot function");
endmodule : system_config_register_bank_sva

bind system_config_register_bank system_config_register_bank_sva #(
  .MAKER_ID(MAKER_ID),
  .REVISION(REVISION)
) sva (
  .core_clk          (core_clk),
  .resetn            (resetn),
  .busAddr           (busAddr),
  .busWdata          (busWdata),
  .busWrite          (busWrite),
  .busRead           (busRead),
  .busRdata          (busRdata),
  .bootPinAltSelected(bootPinAltSelected),
  .bootRomAtZero     (bootRomAtZero),
  .nmiConfig         (nmiConfig),
  .systemResetReq    (systemResetReq)
);

// ==== system_config_register_bank_tb.sv ====
// Self-checking testbench of the system configuration register bank
module system_config_register_bank_tb
  import scu_config_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [31:0] MAKER = 32'h1234_5678; // Arbitrary value
  localparam logic [7:0]  REV   = 8'h3c;         // Arbitrary value
  localparam int SRC_FLAG [5] = '{FLAG_EXT, FLAG_LVR, FLAG_WDT, FLAG_MON, FLAG_POR};
  logic core_clk, resetn, busWrite, busRead, extResetPinN, lvrResetReq, wdtResetReq;
  logic monResetReq, deepWakeReset, bootPin, bootPinAltSelected, cfgOptionValid;
  logic [31:0] busAddr, busWdata, busRdata, cfgOptionData, d, e;
  logic bootRomAtZero, systemResetReq, bootPinDefaultLoad;
  logic [7:0] nmiConfig;
  logic [1:0] bootCheckIndicator;
  int fails, totalChecks;

  system_config_register_bank #(.MAKER_ID(MAKER), .REVISION(REV)) dut (.*);

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  function automatic logic [31:0] cfg(input logic [7:0] o);
    return CHIP_CFG_BASE + {24'h0, o};
  endfunction : cfg

  function automatic logic [31:0] remap_word(input logic [7:0] v);
    return {REMAP_KEY, ~v, v};
  endfunction : remap_word

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask : check

  task automatic bus_write(input logic [31:0] addr, input logic [31:0] data);
    @(posedge core_clk);
    busWrite <= 1'b1;
    busAddr  <= addr;
    busWdata <= data;
    @(posedge core_clk);
    busWrite <= 1'b0;
  endtask : bus_write

  task automatic read_check(input string name, input logic [31:0] addr, input logic [31:0] exp);
    @(posedge core_clk);
    busRead <= 1'b1;
    busAddr <= addr;
    @(posedge core_clk);
    busRead <= 1'b0;
    #1;
    check(name, busRdata, exp);
  endtask : read_check

  task automatic fire_source(input int src);
    @(posedge core_clk);
    case (src)
      0: extResetPinN <= 1'b0;
      1: lvrResetReq <= 1'b1;
      2: wdtResetReq <= 1'b1;
      3: monResetReq <= 1'b1;
      default: deepWakeReset <= 1'b1;
    endcase
    repeat (8) @(posedge core_clk);
    extResetPinN  <= 1'b1;
    lvrResetReq   <= 1'b0;
    wdtResetReq   <= 1'b0;
    monResetReq   <= 1'b0;
    deepWakeReset <= 1'b0;
    repeat (8) @(posedge core_clk);
  endtask : fire_source

  task automatic final_report();
    $display("checks %0d, mismatches %0d", totalChecks, fails);
    if (fails == 0 && totalChecks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report

  initial begin
    #2_000_000;
    fails++;
    final_report();
  end

  initial begin
    {resetn, busWrite, busRead, lvrResetReq, wdtResetReq, monResetReq} = '0;
    {deepWakeReset, cfgOptionValid, busAddr, busWdata, cfgOptionData} = '0;
    {extResetPinN, bootPin, bootPinAltSelected} = 3'b111;
    d = $urandom(32'h824d1bac);
    repeat (6) @(posedge core_clk);
    check("pin default load", {31'h0, bootPinDefaultLoad}, 32'h1);
    resetn <= 1'b1;
    read_check("flags at power-on", cfg(OFS_RST_FLAGS), {26'h0, FLAGS_AT_POR});
    read_check("maker word", cfg(OFS_MAKER_ID), MAKER);
    read_check("revision", cfg(OFS_REVISION), {24'h0, REV});
    read_check("validation", cfg(OFS_RST_VALID), RESET_VALID_VAL);
    read_check("timer data", cfg(OFS_WUT_RELOAD), WUT_DATA_RESET);
    read_check("nmi at reset", cfg(OFS_NMI_SEL), 32'h0);
    read_check("lv control", LOW_VOLT_BASE + 32'h4, LOW_VOLT_RESET);
    d = $urandom();
    bus_write(LOW_VOLT_BASE, d);
    read_check("lv storage", LOW_VOLT_BASE, d);
    bus_write(cfg(OFS_WUT_CTRL), 32'hffff_ffff);
    bus_write(cfg(OFS_WUT_RELOAD), 32'hffff_ffff);
    read_check("timer control", cfg(OFS_WUT_CTRL), WUT_CTRL_MASK);
    read_check("timer data mask", cfg(OFS_WUT_RELOAD), WUT_DATA_MASK);
    for (int i = 0; i < CLK_REG_COUNT; i++) begin
      read_check("clock reset", CLK_GEN_BASE + {24'h0, CLK_OFS[i]}, CLK_RST[i]);
      d = $urandom();
      bus_write(CLK_GEN_BASE + {24'h0, CLK_OFS[i]}, d);
      read_check("clock storage", CLK_GEN_BASE + {24'h0, CLK_OFS[i]}, d);
    end
    e = $urandom();
    @(posedge core_clk);
    cfgOptionValid <= 1'b1;
    cfgOptionData  <= e;
    @(posedge core_clk);
    cfgOptionValid <= 1'b0;
    foreach (d[i]) if (i < 4) bus_write(cfg(8'(4 * i)), $urandom());
    read_check("part word", cfg(OFS_PART_ID), e);
    read_check("maker after write", cfg(OFS_MAKER_ID), MAKER);
    bus_write(cfg(8'h0c), $urandom());
    read_check("unused offset", cfg(8'h0c), 32'h0);
    read_check("trim hole", cfg(8'ha8), 32'h0);
    bus_write(cfg(OFS_REMAP), remap_word(REMAP_BOOT_CODE));
    read_check("remap boot", cfg(OFS_REMAP), {24'h0, REMAP_BOOT_CODE});
    check("boot rom at zero", {31'h0, bootRomAtZero}, 32'h1);
    bus_write(cfg(OFS_REMAP), {16'he2f0, 16'hff00});
    read_check("bad key", cfg(OFS_REMAP), {24'h0, REMAP_BOOT_CODE});
    bus_write(cfg(OFS_REMAP), {REMAP_KEY, 16'h0000});
    read_check("bad inverse", cfg(OFS_REMAP), {24'h0, REMAP_BOOT_CODE});
    e = {24'h0, 8'($urandom()) | 8'h80};
    bus_write(cfg(OFS_REMAP), remap_word(e[7:0]));
    read_check("remap flash", cfg(OFS_REMAP), e);
    check("flash at zero", {31'h0, bootRomAtZero}, 32'h0);
    for (int i = 0; i < 4; i++) begin
      d = (i == 0) ? 32'hffff_ffff : $urandom();
      bus_write(cfg(OFS_NMI_SEL), d);
      read_check("nmi storage", cfg(OFS_NMI_SEL), {24'h0, d[7:0] & NMI_FIELD_MASK});
      check("nmi output", {24'h0, nmiConfig}, {24'h0, d[7:0] & NMI_FIELD_MASK});
    end
    bus_write(cfg(OFS_BOOT_PIN), 32'hffff_ffff);
    for (int i = 0; i < 3; i++) begin
      @(posedge core_clk);
      bootPin            <= i[0];
      bootPinAltSelected <= (i < 2);
      repeat (4) @(posedge core_clk);
      read_check("boot status", cfg(OFS_BOOT_PIN), {25'h0, 2'b11, 4'h0, i != 0});
    end
    for (int s = 0; s < 5; s++) begin
      bus_write(cfg(OFS_BOOT_PIN), 32'h60);
      bus_write(cfg(OFS_RST_FLAGS), 32'h3f);
      fire_source(s);
      e = (s < 4) ? 32'h1 << SRC_FLAG[s] : 32'h0;
      read_check("source flag", cfg(OFS_RST_FLAGS), e);
      check("indicator", {30'h0, bootCheckIndicator}, (s == 0) ? 32'h1 : 32'h3);
      bus_write(cfg(OFS_RST_FLAGS), ~e);
      read_check("flag kept", cfg(OFS_RST_FLAGS), e);
      bus_write(cfg(OFS_RST_FLAGS), e);
      read_check("flag cleared", cfg(OFS_RST_FLAGS), 32'h0);
    end
    for (int i = 0; i < 3; i++) begin
      d = {(i == 1) ? 16'h9eb2 : SW_RESET_KEY, 8'h00, (i == 0) ? 8'h2c : SW_RESET_CODE};
      bus_write(cfg(OFS_SW_RESET), d);
      #1;
      check("reset request", {31'h0, systemResetReq}, {31'h0, i == 2});
      check("pin reload", {31'h0, bootPinDefaultLoad}, {31'h0, i == 2});
    end
    repeat (8) @(posedge core_clk);
    read_check("software flag", cfg(OFS_RST_FLAGS), 32'h1 << FLAG_SW);
    @(posedge core_clk);
    resetn <= 1'b0;
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    check("indicator at power-on", {30'h0, bootCheckIndicator}, 32'h0);
    read_check("flags again", cfg(OFS_RST_FLAGS), {26'h0, FLAGS_AT_POR});
    final_report();
  end
endmodule : system_config_register_bank_tb
